/* logic/dcpp_pkg.sv */
// Shared constants and types for the display controller peripheral port
package dcpp_pkg;
    localparam int CLK_HZ          = 10_000_000;
    localparam int SYNC_STAGES     = 3;
    // Light source select codes
    localparam logic [1:0] LS_NONE  = 2'h0;
    localparam logic [1:0] LS_RED   = 2'h1;
    localparam logic [1:0] LS_GREEN = 2'h2;
    localparam logic [1:0] LS_BLUE  = 2'h3;
    // Flash boot read
    localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
    localparam logic [23:0] FLASH_BASE_ADDR = 24'h0000_00;
    localparam int          FLASH_HDR_BITS  = 32;
    localparam int          SEQ_LEN         = 8;
    // Control port target address, arbitrary value
    localparam logic [6:0]  I2C_TARGET_ADDR = 7'h1b;
    // Sequencer step and comparator settle times
    localparam int STEP_TIME_US   = 100;
    localparam int STEP_CYCLES    = (STEP_TIME_US * CLK_HZ) / 1_000_000;
    localparam int SETTLE_TIME_US = 50;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int SAR_BITS       = 8;
    typedef enum logic [1:0] {INIT_BOOT, INIT_LOAD, INIT_RUN} dcpp_init_t;
    typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD,
                              I2C_RACK} dcpp_i2c_t;
    typedef enum logic [1:0] {FL_IDLE, FL_XFER, FL_DONE} dcpp_flash_t;
endpackage

/* logic/dcpp_flash_reader.sv */
// Serial flash boot reader running on the flash link clock
`timescale 1ns/100ps
module dcpp_flash_reader #(
    parameter int SEQ_BYTES = dcpp_pkg::SEQ_LEN
) (
    input  wire logic                   flash_clk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire logic                   load_req,
    output logic                        load_done,
    output logic [SEQ_BYTES*8-1:0]      table_data,
    output logic                        flash_serial_clock,
    output logic                        flash_select_primary_n,
    output logic                        flash_select_spare_n,
    output logic                        flash_serial_out,
    input  wire logic                   flash_serial_in
);
    import dcpp_pkg::*;
    localparam int TOTAL = FLASH_HDR_BITS + SEQ_BYTES * 8;
    localparam int CW    = $clog2(TOTAL + 1);

    logic [1:0]        rst_q;
    logic              frst;
    logic [1:0]        req_q;
    logic [1:0]        en_q;
    dcpp_flash_t       st_q;
    logic              ph_q;
    logic [CW-1:0]     cnt_q;
    logic [31:0]       tx_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and control crossing into the link domain
    always_ff @(posedge flash_clk or posedge reset) begin
        if (reset) begin
            rst_q <= 2'h3;
        end else begin
            rst_q <= {rst_q[0], 1'b0};
        end
    end
    assign frst = rst_q[1];

    always_ff @(posedge flash_clk or posedge frst) begin
        if (frst) begin
            req_q <= 2'h0;
            en_q  <= 2'h0;
        end else begin
            req_q <= {req_q[0], load_req};
            en_q  <= {en_q[0], clk_en};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read command, address, then the table, mode 0
    always_ff @(posedge flash_clk or posedge frst) begin
        if (frst) begin
            st_q                   <= FL_IDLE;
            ph_q                   <= 1'b0;
            cnt_q                  <= '0;
            tx_q                   <= 32'h0000_0000;
            table_data             <= '0;
            flash_serial_clock     <= 1'b0;
            flash_select_primary_n <= 1'b1;
            load_done              <= 1'b0;
        end else if (en_q[1]) begin
            unique case (st_q)
                FL_IDLE: begin
                    if (req_q[1]) begin
                        flash_select_primary_n <= 1'b0;
                        tx_q  <= {FLASH_READ_CMD, FLASH_BASE_ADDR};
                        cnt_q <= '0;
                        ph_q  <= 1'b0;
                        st_q  <= FL_XFER;
                    end
                end
                FL_XFER: begin
                    if (!ph_q) begin
                        flash_serial_clock <= 1'b1;
                        if (cnt_q >= CW'(FLASH_HDR_BITS)) begin
                            table_data <= {table_data[SEQ_BYTES*8-2:0], flash_serial_in};
                        end
                        ph_q <= 1'b1;
                    end else begin
                        flash_serial_clock <= 1'b0;
                        tx_q  <= {tx_q[30:0], 1'b0};
                        cnt_q <= cnt_q + 1'b1;
                        ph_q  <= 1'b0;
                        if (cnt_q == CW'(TOTAL - 1)) begin
                            flash_select_primary_n <= 1'b1;
                            st_q <= FL_DONE;
                        end
                    end
                end
                FL_DONE: begin
                    load_done <= 1'b1;
                end
            endcase
        end
    end

    assign flash_serial_out     = tx_q[31];
    // Spare select is never used by the boot path
    assign flash_select_spare_n = 1'b1;

    a_clock_framed: assert property (@(posedge flash_clk) disable iff (frst)
        flash_serial_clock |-> !flash_select_primary_n)
        else $error("flash clock high outside chip select");
    a_spare_idle: assert property (@(posedge flash_clk) disable iff (frst)
        flash_select_spare_n)
        else $error("spare chip select asserted");
endmodule

/* logic/dcpp_periph_port.sv */
// Peripheral pin logic: boot, light select, control port, flash, thermistor
`timescale 1ns/100ps
module dcpp_periph_port #(
    parameter logic [6:0] TARGET_ADDR = dcpp_pkg::I2C_TARGET_ADDR,
    parameter int         SEQ_BYTES   = dcpp_pkg::SEQ_LEN
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire logic                   flash_clk,
    output logic                        host_irq_out,
    output logic                        host_irq_oe,
    output logic [1:0]                  light_source_select,
    input  wire logic                   ctrl_port_clock_in,
    output logic                        ctrl_port_clock_out,
    output logic                        ctrl_port_clock_oe,
    input  wire logic                   ctrl_port_data_in,
    output logic                        ctrl_port_data_out,
    output logic                        ctrl_port_data_oe,
    output logic [7:0]                  cmd_byte,
    output logic                        cmd_valid,
    output logic                        flash_serial_clock,
    output logic                        flash_select_primary_n,
    output logic                        flash_select_spare_n,
    output logic                        flash_serial_out,
    input  wire logic                   flash_serial_in,
    input  wire logic                   thermistor_comparator_in,
    input  wire logic                   ref_charge_enable,
    output logic                        reference_charge_drive,
    input  wire logic                   therm_start,
    output logic [dcpp_pkg::SAR_BITS-1:0] therm_result,
    output logic                        therm_done,
    output logic                        init_done
);
    import dcpp_pkg::*;
    localparam int IW = $clog2(SAR_BITS);
    localparam int XW = $clog2(SEQ_BYTES);

    logic [2:0]                  pin_raw;
    logic [2:0]                  pin_f;
    logic [2:0]                  pin_p_q;
    logic                        scl_f;
    logic                        sda_f;
    logic                        cmp_f;
    dcpp_init_t                  init_q;
    logic                        load_req_q;
    logic [2:0]                  done_s_q;
    logic                        irq_q;
    logic                        irq_oe_q;
    logic [SEQ_BYTES*8-1:0]      table_data;
    logic [1:0]                  seq_q [SEQ_BYTES];
    logic [$clog2(SEQ_BYTES)-1:0] idx_q;
    logic [15:0]                 step_q;
    logic [1:0]                  lss_q;
    logic                        done_raw;
    logic                        done_seen;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_cond;
    logic                        stop_cond;
    dcpp_i2c_t                   i2c_q;
    logic [3:0]                  bit_cnt_q;
    logic [7:0]                  sh_q;
    logic                        rw_q;
    logic                        nack_q;
    logic                        sda_oe_q;
    logic                        busy_q;
    logic [SAR_BITS-1:0]         sar_q;
    logic [SAR_BITS-1:0]         sar_keep;
    logic [IW-1:0]               bit_idx_q;
    logic [15:0]                 settle_q;
    logic                        charge_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers, a change counts once stages two and three agree
    assign pin_raw = {thermistor_comparator_in, ctrl_port_data_in, ctrl_port_clock_in};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            logic [SYNC_STAGES-1:0] sync_q;
            logic                   filt_q;
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    sync_q <= '1;
                    filt_q <= 1'b1;
                end else if (clk_en) begin
                    sync_q <= {sync_q[SYNC_STAGES-2:0], pin_raw[i]};
                    if (sync_q[1] == sync_q[2]) begin
                        filt_q <= sync_q[2];
                    end
                end
            end
            assign pin_f[i] = filt_q;
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_p_q <= 3'h7;
        end else if (clk_en) begin
            pin_p_q <= pin_f;
        end
    end
    assign scl_f = pin_f[0];
    assign sda_f = pin_f[1];
    assign cmp_f = pin_f[2];

    ////////////////////////////////////////////////////////////////////////////
    // Auto-init: boot table comes from flash over the link domain
    dcpp_flash_reader #(
        .SEQ_BYTES              (SEQ_BYTES)
    ) u_flash (
        .flash_clk              (flash_clk),
        .reset                  (reset),
        .clk_en                 (clk_en),
        .load_req               (load_req_q),
        .load_done              (done_raw),
        .table_data             (table_data),
        .flash_serial_clock     (flash_serial_clock),
        .flash_select_primary_n (flash_select_primary_n),
        .flash_select_spare_n   (flash_select_spare_n),
        .flash_serial_out       (flash_serial_out),
        .flash_serial_in        (flash_serial_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Done crosses back on three flops; the table is quiet by then, so it is read as is
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_s_q <= 3'h0;
        end else if (clk_en) begin
            done_s_q <= {done_s_q[1:0], done_raw};
        end
    end
    assign done_seen = done_s_q[1] & done_s_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // Auto-init sequencing and the host interrupt
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_q     <= INIT_BOOT;
            load_req_q <= 1'b0;
            irq_q      <= 1'b1;
            irq_oe_q   <= 1'b0;
            init_done  <= 1'b0;
        end else if (clk_en) begin
            unique case (init_q)
                INIT_BOOT: begin
                    irq_oe_q <= 1'b1;
                    irq_q    <= 1'b1;
                    init_q   <= INIT_LOAD;
                end
                INIT_LOAD: begin
                    load_req_q <= 1'b1;
                    if (done_seen) begin
                        irq_q     <= 1'b0;
                        init_done <= 1'b1;
                        init_q    <= INIT_RUN;
                    end
                end
                INIT_RUN: begin
                    irq_q <= 1'b0;
                end
                default: begin
                    init_q <= INIT_BOOT;
                end
            endcase
        end
    end
    // Released in reset; the board pull-up gives the level until the first clock
    assign host_irq_out = irq_q;
    assign host_irq_oe  = irq_oe_q;

    a_irq_released: assert property (@(posedge clk) reset |-> !host_irq_oe)
        else $error("interrupt driven during reset");
    a_irq_init_high: assert property (@(posedge clk) disable iff (reset)
        (init_q == INIT_LOAD) |-> (host_irq_oe && host_irq_out))
        else $error("interrupt not high during init");

    ////////////////////////////////////////////////////////////////////////////
    // Display sequence: two-bit light codes packed from the low end of the table
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int e = 0; e < SEQ_BYTES; e++) begin
                seq_q[e] <= LS_NONE;
            end
        end else if (clk_en && init_q == INIT_LOAD && done_seen) begin
            for (int e = 0; e < SEQ_BYTES; e++) begin
                seq_q[e] <= table_data[2*e +: 2];
            end
        end
    end

    // Software never reaches these pins; only the sequence steps them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idx_q  <= '0;
            step_q <= 16'h0000;
            lss_q  <= LS_NONE;
        end else if (clk_en && init_q == INIT_RUN) begin
            if (step_q == 16'(STEP_CYCLES - 1)) begin
                step_q <= 16'h0000;
                lss_q  <= seq_q[idx_q];
                if (idx_q == XW'(SEQ_BYTES - 1)) begin
                    idx_q <= '0;
                end else begin
                    idx_q <= idx_q + 1'b1;
                end
            end else begin
                step_q <= step_q + 16'h0001;
            end
        end
    end
    assign light_source_select = lss_q;

    a_select_reset: assert property (@(posedge clk)
        reset |-> light_source_select == LS_NONE)
        else $error("light select lit during reset");
    a_select_dark_init: assert property (@(posedge clk) disable iff (reset)
        init_q != INIT_RUN |-> light_source_select == LS_NONE)
        else $error("light select lit during init");

    ////////////////////////////////////////////////////////////////////////////
    // Control port target; no clock stretching, so its clock line is never pulled
    assign scl_rise   = scl_f & ~pin_p_q[0];
    assign scl_fall   = ~scl_f & pin_p_q[0];
    assign start_cond = scl_f & pin_p_q[0] & pin_p_q[1] & ~sda_f;
    assign stop_cond  = scl_f & pin_p_q[0] & ~pin_p_q[1] & sda_f;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            i2c_q     <= I2C_IDLE;
            bit_cnt_q <= 4'h0;
            sh_q      <= 8'h00;
            rw_q      <= 1'b0;
            nack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
            cmd_byte  <= 8'h00;
            cmd_valid <= 1'b0;
        end else if (clk_en) begin
            cmd_valid <= 1'b0;
            if (stop_cond) begin
                i2c_q    <= I2C_IDLE;
                sda_oe_q <= 1'b0;
            end else if (start_cond) begin
                i2c_q     <= I2C_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end else begin
                unique case (i2c_q)
                    I2C_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    I2C_ADDR, I2C_WR: begin
                        if (scl_rise) begin
                            sh_q      <= {sh_q[6:0], sda_f};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (i2c_q == I2C_WR) begin
                                cmd_byte  <= sh_q;
                                cmd_valid <= 1'b1;
                                sda_oe_q  <= 1'b1;
                                i2c_q     <= I2C_WACK;
                            end else if (sh_q[7:1] == TARGET_ADDR) begin
                                rw_q     <= sh_q[0];
                                sda_oe_q <= 1'b1;
                                i2c_q    <= I2C_AACK;
                            end else begin
                                i2c_q <= I2C_IDLE;
                            end
                        end
                    end
                    I2C_AACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                sh_q     <= cmd_byte;
                                sda_oe_q <= ~cmd_byte[7];
                                i2c_q    <= I2C_RD;
                            end else begin
                                sda_oe_q <= 1'b0;
                                i2c_q    <= I2C_WR;
                            end
                        end
                    end
                    I2C_WACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            i2c_q    <= I2C_WR;
                        end
                    end
                    I2C_RD: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                bit_cnt_q <= 4'h0;
                                sda_oe_q  <= 1'b0;
                                i2c_q     <= I2C_RACK;
                            end else begin
                                sh_q     <= {sh_q[6:0], 1'b0};
                                sda_oe_q <= ~sh_q[6];
                            end
                        end
                    end
                    I2C_RACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_f;
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                i2c_q <= I2C_IDLE;
                            end else begin
                                sh_q     <= cmd_byte;
                                sda_oe_q <= ~cmd_byte[7];
                                i2c_q    <= I2C_RD;
                            end
                        end
                    end
                    default: begin
                        i2c_q <= I2C_IDLE;
                    end
                endcase
            end
        end
    end
    // Open drain: the only level ever driven is low
    assign ctrl_port_clock_out = 1'b0;
    assign ctrl_port_clock_oe  = 1'b0;
    assign ctrl_port_data_out  = 1'b0;
    assign ctrl_port_data_oe   = sda_oe_q;

    a_ack_low: assert property (@(posedge clk) disable iff (reset)
        (i2c_q == I2C_AACK || i2c_q == I2C_WACK) |-> (ctrl_port_data_oe && !ctrl_port_data_out))
        else $error("acknowledge not pulled low");

    ////////////////////////////////////////////////////////////////////////////
    // Thermistor conversion, one settle time per bit; slow but needs no charge timing
    always_comb begin
        sar_keep = sar_q;
        if (!cmp_f) begin
            sar_keep[bit_idx_q] = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q       <= 1'b0;
            sar_q        <= '0;
            bit_idx_q    <= '0;
            settle_q     <= 16'h0000;
            charge_q     <= 1'b0;
            therm_result <= '0;
            therm_done   <= 1'b0;
        end else if (clk_en) begin
            if (!busy_q) begin
                charge_q <= 1'b0;
                if (therm_start) begin
                    busy_q     <= 1'b1;
                    sar_q      <= {1'b1, {(SAR_BITS-1){1'b0}}};
                    bit_idx_q  <= IW'(SAR_BITS - 1);
                    settle_q   <= 16'h0000;
                    therm_done <= 1'b0;
                end
            end else begin
                charge_q <= ref_charge_enable;
                if (settle_q == 16'(SETTLE_CYCLES - 1)) begin
                    settle_q <= 16'h0000;
                    if (bit_idx_q == '0) begin
                        busy_q       <= 1'b0;
                        charge_q     <= 1'b0;
                        therm_result <= sar_keep;
                        therm_done   <= 1'b1;
                    end else begin
                        sar_q                <= sar_keep;
                        sar_q[bit_idx_q - 1'b1] <= 1'b1;
                        bit_idx_q            <= bit_idx_q - 1'b1;
                    end
                end else begin
                    settle_q <= settle_q + 16'h0001;
                end
            end
        end
    end
    assign reference_charge_drive = charge_q;

    sequence s_conv_req;
        clk_en && therm_start && !busy_q;
    endsequence
    sequence s_conv_msb;
        busy_q && !therm_done && bit_idx_q == IW'(SAR_BITS - 1);
    endsequence
    a_sar_start: assert property (@(posedge clk) disable iff (reset)
        s_conv_req |=> s_conv_msb)
        else $error("conversion did not start at the top bit");
    a_charge_busy: assert property (@(posedge clk) disable iff (reset)
        reference_charge_drive |-> busy_q)
        else $error("charge output outside conversion");
endmodule

/* test/dcpp_flash_model.sv */
// Serial flash memory model answering the boot read of the peripheral port
`timescale 1ns/100ps
module dcpp_flash_model (
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic mosi,
    output logic      miso
);
    import dcpp_pkg::*;
    // Every byte 6d, so any two-bit field picked from it is a lit source
    localparam logic [7:0] SEQ_BYTE = 8'h6d;
    logic [31:0] hdr    = 32'h0000_0000;
    logic        bit_q  = 1'b0;
    logic        hdr_ok = 1'b0;
    int          cnt    = 0;
    always @(negedge cs_n) begin
        cnt = 0;
    end
    // Command and address are taken on the rising serial clock
    always @(posedge sck) begin
        if (!cs_n) begin
            hdr = {hdr[30:0], mosi};
            cnt = cnt + 1;
            if (cnt == 32) hdr_ok = (hdr === {FLASH_READ_CMD, FLASH_BASE_ADDR});
        end
    end
    // Data leaves on the falling clock, MSB first
    always @(negedge sck) begin
        if (!cs_n && cnt >= 32) bit_q <= SEQ_BYTE[7 - ((cnt - 32) % 8)];
    end
    // Deselected, the line shows the inverse of its last bit so stale data never passes
    assign miso = cs_n ? ~bit_q : bit_q;
endmodule

/* test/tb_top.sv */
// Testbench for the peripheral port: boot, light select, control port, thermistor
`timescale 1ns/100ps
module tb_top;
    import dcpp_pkg::*;
    logic clk = 0, fclk = 0, reset = 0, comp = 0, start = 0, hs_low = 0, hd_low = 0;
    logic park_req_n = 1'b1;
    logic irq_o, irq_oe, sco, scoe, sdo, sdoe, cmdv, fsck, fcs, fspare, fmosi, fmiso;
    logic rcd, tdone, idone;
    logic [1:0]          ls;
    logic [7:0]          cmd;
    logic [7:0]          got = 8'h00;
    logic [SAR_BITS-1:0] tres;
    int                  fails = 0;
    int                  samples_checked = 0;
    initial forever #50 clk = ~clk;
    initial begin
        #3;
        forever #7.5 fclk = ~fclk;
    end
    // Pull-ups on the open-drain lines and the interrupt
    wire scl = (scoe ? sco : 1'b1) & ~hs_low;
    wire sda = (sdoe ? sdo : 1'b1) & ~hd_low;
    wire irq = irq_oe ? irq_o : 1'b1;
    dcpp_periph_port u_dcpp_periph_port (.clk(clk), .reset(reset), .clk_en(1'b1),
        .flash_clk(fclk), .host_irq_out(irq_o), .host_irq_oe(irq_oe),
        .light_source_select(ls), .ctrl_port_clock_in(scl), .ctrl_port_clock_out(sco),
        .ctrl_port_clock_oe(scoe), .ctrl_port_data_in(sda), .ctrl_port_data_out(sdo),
        .ctrl_port_data_oe(sdoe), .cmd_byte(cmd), .cmd_valid(cmdv),
        .flash_serial_clock(fsck), .flash_select_primary_n(fcs),
        .flash_select_spare_n(fspare), .flash_serial_out(fmosi), .flash_serial_in(fmiso),
        .thermistor_comparator_in(comp), .ref_charge_enable(1'b1),
        .reference_charge_drive(rcd), .therm_start(start), .therm_result(tres),
        .therm_done(tdone), .init_done(idone));
    dcpp_flash_model u_dcpp_flash_model (.sck(fsck), .cs_n(fcs), .mosi(fmosi), .miso(fmiso));
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (!reset) begin
            chk(!(scoe && sco !== 1'b0) && !(sdoe && sdo !== 1'b0), "line driven high");
            chk(fspare === 1'b1, "spare select active");
            chk(park_req_n === 1'b1 || irq === 1'b0, "park request before init end");
            if (cmdv === 1'b1) got = cmd;
        end
    end
    task automatic i2c_bit(input logic b, output logic r);
        hd_low <= ~b;
        hold(10);
        hs_low <= 1'b0;
        hold(10);
        @(negedge clk) r = sda;
        @(posedge clk) hs_low <= 1'b1;
        hold(9);
    endtask
    task automatic i2c_write(input logic [6:0] a, input logic [7:0] d, output logic ack);
        logic [17:0] f;
        logic        r;
        f = {a, 1'b0, 1'b1, d, 1'b1};
        ack = 1'b1;
        hd_low <= 1'b1;
        hold(10);
        hs_low <= 1'b1;
        hold(10);
        for (int i = 17; i >= 0; i--) begin
            i2c_bit(f[i], r);
            if (i == 9 || i == 0) ack = ack & ~r;
        end
        hd_low <= 1'b1;
        hold(10);
        hs_low <= 1'b0;
        hold(10);
        hd_low <= 1'b0;
        hold(40);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_boot;
        int n;
        for (n = 0; n < 50000 && idone !== 1'b1; n++) begin
            @(negedge clk);
            if (idone !== 1'b1) chk(ls === LS_NONE && irq === 1'b1, "state during init");
        end
        chk(n < 50000, "init timeout");
        if (n >= 50000) give_verdict();
        for (n = 0; n < 100 && irq !== 1'b0; n++) @(negedge clk);
        chk(irq === 1'b0, "irq not low after init");
        park_req_n <= 1'b0;
        chk(u_dcpp_flash_model.hdr_ok === 1'b1, "flash read header");
    endtask
    task automatic sc_sequence;
        int seen [4] = '{default: 0};
        int kinds = 0;
        repeat (20000) begin
            @(negedge clk);
            seen[ls] = 1;
        end
        for (int c = 1; c < 4; c++) kinds += seen[c];
        chk(kinds >= 2, "light select not following sequence");
    endtask
    task automatic sc_ctrl;
        logic ack;
        i2c_write(I2C_TARGET_ADDR, 8'ha5, ack);
        chk(ack === 1'b1 && got === 8'ha5, "write to own address");
        i2c_write(I2C_TARGET_ADDR ^ 7'h01, 8'h3c, ack);
        chk(ack === 1'b0 && got === 8'ha5, "foreign address taken");
    endtask
    task automatic sc_therm;
        logic [SAR_BITS-1:0] res [2];
        int n;
        for (int lv = 0; lv < 2; lv++) begin
            comp <= lv[0];
            hold(SYNC_STAGES + 2);
            start <= 1'b1;
            hold(1);
            start <= 1'b0;
            hold(2);
            for (n = 0; n < 20000 && tdone !== 1'b1; n++) @(negedge clk);
            chk(n < 20000, "conversion timeout");
            if (n >= 20000) give_verdict();
            res[lv] = tres;
            hold(2);
        end
        chk(((res[0] ^ res[1]) === '1) && (res[0] === '0 || res[0] === '1), "sar result");
    endtask
    initial begin
        reset <= 1'b1;
        hold(10);
        chk(ls === LS_NONE && irq_oe === 1'b0, "outputs in reset");
        hold(6);
        reset <= 1'b0;
        sc_boot();
        sc_sequence();
        sc_ctrl();
        sc_therm();
        give_verdict();
    end
endmodule
